// file: rtl/sram_host_pkg.sv
// package: pin bundles, timing constants and states for the sram host
package sram_host_pkg;
	localparam int ADDR_W         = 15;
	localparam int DATA_W         = 16;
	localparam int CLK_PERIOD_PS  = 8000;
	// timing figures in their own units
	localparam int READ_CYCLE_MIN_NS        = 10;
	localparam int ADDR_TO_DATA_DELAY_NS    = 10;
	localparam int SELECT_TO_DATA_DELAY_NS  = 10;
	localparam int GATE_TO_DATA_DELAY_NS    = 5;
	localparam int LANE_TO_DATA_DELAY_NS    = 5;
	localparam int WRITE_CYCLE_MIN_NS       = 10;
	localparam int LANE_TO_WRITE_END_NS     = 7;
	localparam int STROBE_TO_FLOAT_DELAY_NS = 5;
	localparam int WRITE_DATA_SETUP_NS      = 6;
	localparam int POWER_TO_FIRST_ACCESS_US = 100;
	// least times round up to whole cycles
	localparam int READ_WAIT_CYC = (ADDR_TO_DATA_DELAY_NS * 1000
		+ CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int READ_CYC_MIN = (READ_CYCLE_MIN_NS * 1000
		+ CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// strobe low long enough for float plus setup, and the pulse width
	localparam int WR_LOW_NS = (STROBE_TO_FLOAT_DELAY_NS
		+ WRITE_DATA_SETUP_NS > LANE_TO_WRITE_END_NS)
		? STROBE_TO_FLOAT_DELAY_NS + WRITE_DATA_SETUP_NS
		: LANE_TO_WRITE_END_NS;
	localparam int WRITE_LOW_CYC = (WR_LOW_NS * 1000 + CLK_PERIOD_PS - 1)
		/ CLK_PERIOD_PS;
	localparam int WRITE_CYC_MIN = (WRITE_CYCLE_MIN_NS * 1000
		+ CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int POWER_WAIT_CYC = (POWER_TO_FIRST_ACCESS_US * 1000000
		+ CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int CNT_W = 16;
	// depth of the data pin synchroniser, counted in the read wait
	localparam int SYNC_CYC = 2;
	// pins toward the memory: address, then active low strobes
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              chip_select_n;
		logic              output_gate_n;
		logic              write_strobe_n;
		logic              low_lane_enable_n;
		logic              high_lane_enable_n;
	} sram_ctrl_t;
	// host request
	typedef struct packed {
		logic              write;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [1:0]        lanes;
	} sram_req_t;
	typedef enum logic [5:0] {
		ST_POWERUP = 6'b000001,
		ST_IDLE    = 6'b000010,
		ST_RD_WAIT = 6'b000100,
		ST_WR_LOW  = 6'b001000,
		ST_RECOVER = 6'b010000,
		ST_DONE    = 6'b100000
	} sram_state_t;
	localparam sram_ctrl_t CTRL_IDLE = '{addr: '0, chip_select_n: 1'b1,
		output_gate_n: 1'b1, write_strobe_n: 1'b1,
		low_lane_enable_n: 1'b1, high_lane_enable_n: 1'b1};
endpackage : sram_host_pkg

// file: rtl/cycle_timer.sv
// down counter giving a one-cycle expiry pulse
`timescale 1ns/1ps
module cycle_timer #(
	parameter int W = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// load and expiry
	input  wire logic         load,
	input  wire logic [W-1:0] count,
	output logic              done
);
	logic [W-1:0] cnt_ff;
	logic         run_ff;

	// counts down from count-1 so done fires count cycles after load
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_ff <= '0;
			run_ff <= 1'b0;
		end else if (load) begin
			cnt_ff <= count - W'(1);
			run_ff <= 1'b1;
		end else if (run_ff && cnt_ff != '0) begin
			cnt_ff <= cnt_ff - W'(1);
		end else begin
			run_ff <= 1'b0;
		end
	end

	// no load term: the caller reloads on done, which would close a loop
	assign done = run_ff && (cnt_ff == '0);
endmodule : cycle_timer

// file: rtl/sram_host.sv
// host controller driving an asynchronous 32k x 16 sram with byte lanes
// Function
// - host holds strobe high on reads, select, gate, lanes low
// - host sets address no later than select falling
// - host holds lanes, select, strobe 7 ns; writes 10 ns apart
// - strobe-controlled write lasts float time plus data setup
// - host waits 100 us after power before first access
`timescale 1ns/1ps
module sram_host
	import sram_host_pkg::*;
#(
	parameter int POWER_WAIT = POWER_WAIT_CYC
) (
	// clock and reset
	input  wire logic                      clk,
	input  wire logic                      resetn,
	// request side
	input  wire logic                      req_valid,
	input  wire sram_host_pkg::sram_req_t  req,
	output logic                           req_ready,
	output logic                           rsp_valid,
	output logic [sram_host_pkg::DATA_W-1:0] rsp_data,
	// memory pins
	output sram_host_pkg::sram_ctrl_t      pins,
	output logic [sram_host_pkg::DATA_W-1:0] dq_out,
	output logic [sram_host_pkg::DATA_W-1:0] dq_oe,
	input  wire logic [sram_host_pkg::DATA_W-1:0] dq_in
);
	import sram_host_pkg::*;

	sram_state_t             state_ff;
	sram_ctrl_t              pins_ff;
	logic [DATA_W-1:0]       dq_out_ff;
	logic [DATA_W-1:0]       dq_oe_ff;
	logic [DATA_W-1:0]       dq_s1_ff;
	logic [DATA_W-1:0]       dq_s2_ff;
	logic                    req_ready_ff;
	logic                    rsp_valid_ff;
	logic [DATA_W-1:0]       rsp_data_ff;
	logic [1:0]              lanes_ff;
	logic                    is_write_ff;
	logic                    t_load;
	logic [CNT_W-1:0]        t_count;
	logic                    t_done;
	logic [31:0]             pwr_cnt_ff;

	// one access: take, strobes low for the timed phase, strobes high,
	// recovery pads the cycle out, then done and idle before next take
	// one timer serves both timed phases of an access; reads add two cycles for the synchroniser
	cycle_timer #(.W(CNT_W)) u_timer (
		.clk    (clk),
		.resetn (resetn),
		.load   (t_load),
		.count  (t_count),
		.done   (t_done)
	);

	// pin inputs pass two flops before use
	// their reset value is never used, reads sample only after the wait
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			dq_s1_ff <= '0;
			dq_s2_ff <= '0;
		end else begin
			dq_s1_ff <= dq_in;
			dq_s2_ff <= dq_s1_ff;
		end
	end

	// power-up wait has its own 32-bit counter; the 16-bit timer only serves accesses
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pwr_cnt_ff <= '0;
		end else if (state_ff == ST_POWERUP) begin
			pwr_cnt_ff <= pwr_cnt_ff + 32'h0000_0001;
		end
	end

	// timer loads on entry to each timed phase
	always_comb begin
		t_load  = 1'b0;
		t_count = CNT_W'(1);
		unique case (state_ff)
			ST_IDLE: begin
				if (req_valid && req_ready_ff) begin
					t_load  = 1'b1;
					t_count = req.write ? CNT_W'(WRITE_LOW_CYC)
						: CNT_W'(READ_WAIT_CYC + SYNC_CYC);
				end
			end
			ST_RD_WAIT, ST_WR_LOW: begin
				if (t_done) begin
					t_load  = 1'b1;
					// recovery holds the strobes high for a whole minimum cycle length
					t_count = is_write_ff ? CNT_W'(WRITE_CYC_MIN)
						: CNT_W'(READ_CYC_MIN);
				end
			end
			default: ;
		endcase
	end

	// sequencer
	// a reset at any time goes back through the full power wait
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_ff <= ST_POWERUP;
		end else begin
			unique case (state_ff)
				ST_POWERUP: if (pwr_cnt_ff >= 32'(POWER_WAIT)) begin
					state_ff <= ST_IDLE;
				end
				ST_IDLE: if (req_valid && req_ready_ff) begin
					state_ff <= req.write ? ST_WR_LOW : ST_RD_WAIT;
				end
				ST_RD_WAIT, ST_WR_LOW: if (t_done) begin
					state_ff <= ST_RECOVER;
				end
				ST_RECOVER: if (t_done) begin
					state_ff <= ST_DONE;
				end
				ST_DONE: state_ff <= ST_IDLE;
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// request capture and handshake
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			req_ready_ff <= 1'b0;
			lanes_ff     <= 2'h0;
			is_write_ff  <= 1'b0;
		end else if (state_ff == ST_IDLE && req_valid && req_ready_ff) begin
			req_ready_ff <= 1'b0;
			lanes_ff     <= req.lanes;
			is_write_ff  <= req.write;
		end else begin
			req_ready_ff <= (state_ff == ST_IDLE) || (state_ff == ST_DONE);
		end
	end

	// pin drive: address moves only with strobes falling, all lanes off = no-op
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pins_ff   <= CTRL_IDLE;
			dq_out_ff <= '0;
			dq_oe_ff  <= '0;
		end else begin
			unique case (state_ff)
				ST_IDLE: if (req_valid && req_ready_ff) begin
					// address set with select falling, never after
					// no lanes still selects; the memory floats and ignores it
					pins_ff.addr          <= req.addr;
					pins_ff.chip_select_n <= 1'b0;
					pins_ff.low_lane_enable_n  <= ~req.lanes[0];
					pins_ff.high_lane_enable_n <= ~req.lanes[1];
					pins_ff.write_strobe_n <= ~req.write;
					// gate stays high on writes so the memory never drives
					pins_ff.output_gate_n  <= req.write;
					dq_out_ff <= req.wdata;
					dq_oe_ff  <= req.write ? {{8{req.lanes[1]}},
						{8{req.lanes[0]}}} : '0;
				end
				ST_RD_WAIT, ST_WR_LOW: if (t_done) begin
					// release strobe, select and lanes at once; address held
					pins_ff.chip_select_n      <= 1'b1;
					pins_ff.write_strobe_n     <= 1'b1;
					pins_ff.output_gate_n      <= 1'b1;
					pins_ff.low_lane_enable_n  <= 1'b1;
					pins_ff.high_lane_enable_n <= 1'b1;
				end
				ST_RECOVER: begin
					// data held one cycle past write end for hold time
					dq_oe_ff <= '0;
				end
				default: ;
			endcase
		end
	end

	// capture read data per lane; unread lane returns zero
	// the sample seen at t_done left the pin two edges earlier, so the
	// wait covers access time plus synchroniser depth
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff  <= '0;
		end else begin
			rsp_valid_ff <= 1'b0;
			if (state_ff == ST_RD_WAIT && t_done) begin
				rsp_valid_ff <= 1'b1;
				rsp_data_ff  <= dq_s2_ff & {{8{lanes_ff[1]}},
					{8{lanes_ff[0]}}};
			end
		end
	end

	assign req_ready = req_ready_ff;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_data  = rsp_data_ff;
	assign pins      = pins_ff;
	assign dq_out    = dq_out_ff;
	assign dq_oe     = dq_oe_ff;
endmodule : sram_host

// file: bench/sram_host_assertions.sv
// checker: pin timing of the sram host
`timescale 1ns/1ps
module sram_host_assertions
	import sram_host_pkg::*;
#(
	parameter int POWER_WAIT = 20
) (
	// clock and reset
	input wire logic	clk,
	input wire logic	resetn,
	// watched outputs
	input wire logic	rsp_valid,
	input wire sram_host_pkg::sram_ctrl_t	pins,
	input wire logic [15:0]	dq_oe
);
	import sram_host_pkg::*;
	logic [15:0] up_cnt_ff;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	// cycles since reset; saturates so it never wraps back into the wait
	always_ff @(posedge clk or negedge resetn)
		if (!resetn) up_cnt_ff <= 16'h0;
		else if (up_cnt_ff != 16'hffff) up_cnt_ff <= up_cnt_ff + 16'h1;
	power_wait_a: assert property (up_cnt_ff < POWER_WAIT
		|-> pins.chip_select_n) else $error("access during power wait");
	read_strobe_a: assert property (!pins.output_gate_n
		|-> pins.write_strobe_n) else $error("strobe low in read");
	write_len_a: assert property ($fell(pins.write_strobe_n)
		|=> !pins.write_strobe_n ##1 pins.write_strobe_n)
		else $error("write pulse length");
	write_addr_a: assert property (!pins.write_strobe_n
		&& !$past(pins.write_strobe_n) |-> $stable(pins.addr))
		else $error("address moved in write");
	sel_addr_a: assert property (!pins.chip_select_n
		&& !$past(pins.chip_select_n) |-> $stable(pins.addr))
		else $error("address moved while selected");
	access_gap_a: assert property ($rose(pins.chip_select_n)
		|=> pins.chip_select_n) else $error("accesses too close");
	gate_off_a: assert property (|dq_oe
		|-> pins.output_gate_n) else $error("gate low while driving");
	read_rsp_a: assert property ($fell(pins.chip_select_n)
		&& pins.write_strobe_n |-> !pins.chip_select_n [*2] ##[1:6]
		rsp_valid) else $error("read answer late");
endmodule : sram_host_assertions

// file: bench/sram_model.sv
// behavioural 32k x 16 memory on the host's pins
`timescale 1ns/1ps
module sram_model
	import sram_host_pkg::*;
#(
	parameter int DLY = 7
) (
	// clock for the float pattern and the writes
	input wire logic	clk,
	// bus from the host
	input wire sram_host_pkg::sram_ctrl_t	pins,
	input wire logic [15:0]	dq_out,
	input wire logic [15:0]	dq_oe,
	output logic [15:0]	dq_in
);
	import sram_host_pkg::*;
	logic [15:0] mem [0:32767];
	logic [15:0] junk = 16'h5a3c;
	logic [15:0] bus, lane_m, drv;
	logic rd, wr;
	// read only with strobe high, so select rising with it stays off
	assign rd = !pins.chip_select_n && !pins.output_gate_n
		&& pins.write_strobe_n;
	assign wr = !pins.chip_select_n && !pins.write_strobe_n;
	assign lane_m = {{8{!pins.high_lane_enable_n}},
		{8{!pins.low_lane_enable_n}}};
	assign drv = rd ? lane_m : 16'h0;
	// undriven bits toggle, so a floating bus never reads as data
	always @(posedge clk) junk <= ~junk;
	assign bus = (dq_out & dq_oe) | (junk & ~dq_oe);
	assign #DLY dq_in = (mem[pins.addr] & drv) | (bus & ~drv);
	// disabled lanes keep their byte
	always @(posedge clk)
		if (wr) mem[pins.addr] <= (mem[pins.addr] & ~lane_m)
			| (bus & lane_m);
endmodule : sram_model

// file: bench/sram_host_tb.sv
// testbench: sram host against the behavioural memory
`timescale 1ns/1ps
`define check(got, exp) begin total_checks++; if ((got) !== (exp)) \
	begin fail_count++; \
	$display("wrong value at %0t: got %0h want %0h", $time, got, exp); \
	end end
module sram_host_tb;
	import sram_host_pkg::*;
	logic	clk = 1'b0;
	logic	resetn = 1'b0;
	logic	req_valid = 1'b0;
	sram_req_t	req = '0;
	logic	req_ready, rsp_valid;
	logic [15:0]	rsp_data, dq_out, dq_oe, dq_in;
	sram_ctrl_t	pins;
	int	fail_count = 0;
	int	total_checks = 0;
	always #4 clk = ~clk;
	sram_host #(.POWER_WAIT(20)) i_sram_host (.clk(clk), .resetn(resetn),
		.req_valid(req_valid), .req(req), .req_ready(req_ready),
		.rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
	sram_model #(.DLY(7)) i_sram_model (.clk(clk), .pins(pins),
		.dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
	task automatic report_and_stop();
		if (fail_count == 0 && total_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : report_and_stop
	// request held until the edge that takes it
	task automatic req_go(input logic w, input logic [14:0] a,
		input logic [15:0] d, input logic [1:0] l);
		int n;
		n = 0;
		// start on an edge, so every drive lands 1 ns after one
		@(posedge clk);
		#1 req_valid = 1'b1;
		req = '{w, a, d, l};
		do @(posedge clk); while (req_ready !== 1'b1 && ++n < 200);
		`check(req_ready, 1'b1)
		#1 req_valid = 1'b0;
	endtask : req_go
	task automatic do_read(input logic [14:0] a, input logic [1:0] l,
		input logic [15:0] exp);
		int n;
		n = 0;
		req_go(1'b0, a, 16'h0, l);
		while (rsp_valid !== 1'b1 && n < 50) begin
			@(posedge clk);
			n++;
		end
		`check(rsp_valid, 1'b1)
		`check(rsp_data, exp)
	endtask : do_read
	// reset, then the host must sit out the power wait
	task automatic t_reset();
		int n;
		n = 0;
		@(posedge clk);
		#1 resetn = 1'b0;
		repeat (6) @(posedge clk);
		`check(pins, CTRL_IDLE)
		`check(dq_oe, 16'h0)
		#1 resetn = 1'b1;
		do @(posedge clk); while (req_ready !== 1'b1 && ++n < 100);
		`check(req_ready, 1'b1)
		`check(n >= 20, 1'b1)
	endtask : t_reset
	// every lane choice, none included, at the top address
	task automatic t_lanes();
		logic [15:0] exp [4];
		exp = '{16'h0000, 16'h00c3, 16'ha500, 16'ha5c3};
		req_go(1'b1, 15'h7fff, 16'ha5c3, 2'b11);
		for (int l = 0; l < 4; l++) do_read(15'h7fff, l[1:0], exp[l]);
	endtask : t_lanes
	// one-lane writes keep the other byte and other words
	task automatic t_partial();
		req_go(1'b1, 15'h0000, 16'h1234, 2'b11);
		req_go(1'b1, 15'h0000, 16'hffee, 2'b01);
		do_read(15'h0000, 2'b11, 16'h12ee);
		req_go(1'b1, 15'h0000, 16'hbbaa, 2'b10);
		do_read(15'h0000, 2'b11, 16'hbbee);
		do_read(15'h7fff, 2'b11, 16'ha5c3);
	endtask : t_partial
	// a reset that cuts a write short, then the host must recover
	task automatic reset_mid_write();
		req_go(1'b1, 15'h0123, 16'h5555, 2'b11);
		t_reset();
		do_read(15'h0123, 2'b00, 16'h0000);
		do_read(15'h7fff, 2'b11, 16'ha5c3);
	endtask : reset_mid_write
	initial begin
		t_reset();
		t_lanes();
		t_partial();
		reset_mid_write();
		report_and_stop();
	end
	// watchdog well past the roughly 1300 ns the run needs
	initial begin
		#20000;
		fail_count++;
		report_and_stop();
	end
endmodule : sram_host_tb
bind sram_host sram_host_assertions #(.POWER_WAIT(POWER_WAIT))
	i_sram_host_assertions (.clk(clk), .resetn(resetn),
	.rsp_valid(rsp_valid), .pins(pins), .dq_oe(dq_oe));
